/* pkg/gpb_pkg.sv */
// constants and carrier types of the eight-pin port with change detection
// assumes a 32-bit Avalon-MM register bus on a 200 MHz core clock
package gpb_pkg;

  localparam int unsigned AV_ADDR_W = 8;
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned KBD_W     = 4;
  localparam int unsigned ANA_W     = 4;

  // register byte offsets
  localparam logic [AV_ADDR_W-1:0] OFS_PORT  = 8'h00;
  localparam logic [AV_ADDR_W-1:0] OFS_LATCH = 8'h04;
  localparam logic [AV_ADDR_W-1:0] OFS_DIR   = 8'h08;
  localparam logic [AV_ADDR_W-1:0] OFS_CTL2  = 8'h0C;
  localparam logic [AV_ADDR_W-1:0] OFS_CTL1  = 8'h10;
  localparam logic [AV_ADDR_W-1:0] OFS_ANA   = 8'h14;

  // field positions
  localparam int unsigned PUN_BIT    = 7;
  localparam int unsigned CMP_EN_BIT = 0;
  localparam int unsigned FLAG_BIT   = 0;
  localparam int unsigned PIN5       = 5;
  localparam int unsigned KBD_LO     = 4;

  // reset values
  localparam logic [PORT_W-1:0] DIR_RST   = 8'hFF;
  localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
  localparam logic [ANA_W-1:0]  ANA_RST   = 4'hF;
  localparam logic [KBD_W-1:0]  SNAP_RST  = 4'h0;
  localparam logic [31:0]       UNMAPPED  = 32'h0000_0000;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned INSTR_NS      = 20;
  localparam int unsigned INSTR_CYCLES  =
    (INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic                 read;
    logic                 write;
    logic [AV_ADDR_W-1:0] address;
    logic [3:0]           byteenable;
    logic [31:0]          writedata;
  } gpb_av_req_t;

  typedef struct packed {
    logic [PORT_W-1:0] pin_out;
    logic [PORT_W-1:0] pin_oe;
    logic [PORT_W-1:0] pullup_en;
  } gpb_pad_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } gpb_bus_state_t;

endpackage : gpb_pkg

/* rtl/gpb_port.sv */
// eight-pin bidirectional port with pull-ups and change detection on pins 7..4
// assumes an Avalon-MM master on core_clk_in; pins arrive asynchronously
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module gpb_port
  import gpb_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire gpb_av_req_t       av_req_in,
  output var  logic [31:0]       av_readdata_out,
  output logic                   av_waitrequest_out,
  input  wire logic [PORT_W-1:0] pin_in,
  output logic      [PORT_W-1:0] pin_out,
  output logic      [PORT_W-1:0] pin_oe_out,
  output logic      [PORT_W-1:0] pullup_en_out,
  input  wire logic              cmp_result_in,
  output var  logic              timer_clk_out,
  output logic                   wake_out
);

  localparam logic [2:0] HOLD_LOAD = 3'(INSTR_CYCLES);
  localparam logic [2:0] HOLD_ZERO = 3'h0;
  localparam logic [2:0] HOLD_ONE  = 3'h1;

  gpb_bus_state_t    bus_state_reg;
  gpb_bus_state_t    bus_state_next;
  logic [PORT_W-1:0] dir_reg;
  logic [PORT_W-1:0] latch_reg;
  logic [ANA_W-1:0]  ana_reg;
  logic              pullup_n_reg;
  logic              cmp_en_reg;
  logic              flag_reg;
  logic              flag_next;
  logic [KBD_W-1:0]  snap_reg;
  logic [2:0]        hold_reg;
  logic [PORT_W-1:0] pin_sync;
  gpb_pad_t          pad;

  // pin synchroniser
  gpb_sync #(
    .W (PORT_W)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .async_in    (pin_in),
    .sync_out    (pin_sync)
  );

  // bus decode
  wire req_any    = av_req_in.read | av_req_in.write;
  wire acked      = (bus_state_reg == BUS_ACK);
  wire wr_ack     = acked & av_req_in.write;
  wire rd_ack     = acked & av_req_in.read;
  wire lane0      = av_req_in.byteenable[0];
  wire sel_port   = (av_req_in.address == OFS_PORT);
  wire sel_latch  = (av_req_in.address == OFS_LATCH);
  wire sel_dir    = (av_req_in.address == OFS_DIR);
  wire sel_ctl2   = (av_req_in.address == OFS_CTL2);
  wire sel_ctl1   = (av_req_in.address == OFS_CTL1);
  wire sel_ana    = (av_req_in.address == OFS_ANA);
  wire [7:0] wd8  = av_req_in.writedata[7:0];

  // writes through the port register land in the latch
  wire wr_latch   = wr_ack & lane0 & (sel_port | sel_latch);
  wire wr_dir     = wr_ack & lane0 & sel_dir;
  wire wr_ctl2    = wr_ack & lane0 & sel_ctl2;
  wire wr_ana     = wr_ack & lane0 & sel_ana;
  wire clr_req    = wr_ack & lane0 & sel_ctl1 & ~wd8[FLAG_BIT];
  wire port_touch = acked & sel_port;

  // digital view of the pins; analogue pins read zero
  wire [PORT_W-1:0] pin_digital = pin_sync & {{(PORT_W-ANA_W){1'b1}}, ~ana_reg};

  // change detection on inputs among pins 7..4
  wire [KBD_W-1:0] kbd_live = pin_sync[PORT_W-1:KBD_LO];
  wire [KBD_W-1:0] kbd_in   = dir_reg[PORT_W-1:KBD_LO];
  wire [KBD_W-1:0] miss_bit = (kbd_live ^ snap_reg) & kbd_in;
  wire             mismatch = |miss_bit;

  // clear accepted only after the holdoff; set dominates
  wire clr_ok = clr_req & (hold_reg == HOLD_ZERO);
  always_comb begin
    flag_next = mismatch | (flag_reg & ~clr_ok);
  end

  // read mux
  wire [31:0] rd_mux =
    sel_port  ? {24'h000000, pin_digital} :
    sel_latch ? {24'h000000, latch_reg} :
    sel_dir   ? {24'h000000, dir_reg} :
    sel_ctl2  ? {24'h000000, pullup_n_reg, 6'h00, cmp_en_reg} :
    sel_ctl1  ? {31'h00000000, flag_reg} :
    sel_ana   ? {28'h0000000, ana_reg} :
    UNMAPPED;

  // one wait state per access
  always_comb begin
    case (bus_state_reg)
      BUS_IDLE: bus_state_next = req_any ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  bus_state_next = BUS_IDLE;
      default:  bus_state_next = BUS_IDLE;
    endcase
  end
  assign av_waitrequest_out = req_any & ~acked;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_state_reg   <= BUS_IDLE;
      av_readdata_out <= UNMAPPED;
    end else begin
      bus_state_reg <= bus_state_next;
      if (req_any & ~acked) begin
        av_readdata_out <= rd_mux;
      end
    end
  end

  // configuration registers
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dir_reg      <= DIR_RST;
      latch_reg    <= LATCH_RST;
      ana_reg      <= ANA_RST;
      pullup_n_reg <= 1'b1;
      cmp_en_reg   <= 1'b0;
    end else begin
      if (wr_dir) begin
        dir_reg <= wd8;
      end
      if (wr_latch) begin
        latch_reg <= wd8;
      end
      if (wr_ana) begin
        ana_reg <= wd8[ANA_W-1:0];
      end
      if (wr_ctl2) begin
        pullup_n_reg <= wd8[PUN_BIT];
        cmp_en_reg   <= wd8[CMP_EN_BIT];
      end
    end
  end

  // snapshot, holdoff and change flag
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      snap_reg <= SNAP_RST;
      hold_reg <= HOLD_ZERO;
      flag_reg <= 1'b0;
    end else begin
      if (port_touch) begin
        snap_reg <= kbd_live;
        hold_reg <= HOLD_LOAD;
      end else if (hold_reg != HOLD_ZERO) begin
        hold_reg <= hold_reg - HOLD_ONE;
      end
      flag_reg <= flag_next;
    end
  end

  // pad drive; pin five may carry the comparator result
  wire [PORT_W-1:0] cmp_mask = {{(PORT_W-PIN5-1){1'b0}}, cmp_en_reg, {PIN5{1'b0}}};
  wire [PORT_W-1:0] drive_val =
    (latch_reg & ~cmp_mask) | ({PORT_W{cmp_result_in}} & cmp_mask);

  always_comb begin
    pad.pin_out   = drive_val;
    pad.pin_oe    = ~dir_reg;
    pad.pullup_en = {PORT_W{~pullup_n_reg}} & dir_reg;
  end

  assign pin_out       = pad.pin_out;
  assign pin_oe_out    = pad.pin_oe;
  assign pullup_en_out = pad.pullup_en;
  assign timer_clk_out = pin_sync[PIN5];
  assign wake_out      = flag_reg;

  // ---------------- assertions ----------------
  bus_answer_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (req_any && !acked) |=> !av_waitrequest_out)
    else $error("bus answer not given after one wait state");

  dir_hiz_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    wr_dir |=> (pin_oe_out == ~$past(wd8)))
    else $error("direction write did not set driver enables");

  latch_drive_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (wr_latch && !cmp_en_reg) |=> (pin_out == $past(wd8)))
    else $error("latch write not driven on pins");

  latch_read_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (req_any && !acked && av_req_in.read && sel_latch)
      |=> (av_readdata_out[7:0] == latch_reg))
    else $error("latch read does not return latch value");

  pullup_out_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (pullup_en_out & pin_oe_out) == 8'h00)
    else $error("pull-up enabled on an output pin");

  pullup_rst_a: assert property (
    @(posedge core_clk_in)
    $fell(rst_in) |-> (pullup_en_out == 8'h00))
    else $error("pull-ups enabled after reset");

  analog_zero_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (req_any && !acked && av_req_in.read && sel_port)
      |=> ((av_readdata_out[3:0] & $past(ana_reg)) == 4'h0))
    else $error("analogue pin read as nonzero");

  out_excluded_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (dir_reg[7:4] == 4'h0 && !flag_reg) |=> !flag_reg)
    else $error("output pins raised change flag");

  mismatch_set_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    mismatch |=> (flag_reg && wake_out))
    else $error("mismatch did not set change flag");

  set_wins_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (mismatch && clr_req) |=> flag_reg)
    else $error("clear beat a simultaneous set");

  snap_update_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    port_touch |=> (snap_reg == $past(kbd_live)) ##1 (hold_reg == HOLD_LOAD - HOLD_ONE))
    else $error("port access did not refresh snapshot and holdoff");

  clear_hold_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (flag_reg && clr_req && hold_reg != 3'h0) |=> flag_reg)
    else $error("flag cleared inside holdoff");

  flag_clear_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (flag_reg && clr_ok && !mismatch) |=> !flag_reg)
    else $error("accepted clear did not drop change flag");

  flag_sticky_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (flag_reg && !clr_ok) |=> flag_reg)
    else $error("change flag dropped without accepted clear");

  pullup_on_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (wr_ctl2 && !wd8[PUN_BIT]) |=> (pullup_en_out == dir_reg))
    else $error("pull-ups not enabled on input pins");

  readback_hold_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    !req_any |=> $stable(av_readdata_out))
    else $error("read data changed without a request");

endmodule : gpb_port
`default_nettype wire

/* rtl/gpb_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pin levels; output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module gpb_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic val_reg;
      always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          s1_reg  <= 1'b0;
          s2_reg  <= 1'b0;
          s3_reg  <= 1'b0;
          val_reg <= 1'b0;
        end else begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            val_reg <= s3_reg;
          end
        end
      end
      assign sync_out[i] = val_reg;
    end
  endgenerate

endmodule : gpb_sync
`default_nettype wire

/* testbench/gpb_keypad.sv */
// board model of the eight port pins: switches, pull-ups, floating lines
// assumes pad controls from gpb_port and switch settings from the bench
`timescale 1ns/10ps
`default_nettype none
module gpb_keypad
  import gpb_pkg::*;
(
  input  wire logic [PORT_W-1:0] pin_out_in,
  input  wire logic [PORT_W-1:0] pin_oe_in,
  input  wire logic [PORT_W-1:0] pullup_en_in,
  input  wire logic [PORT_W-1:0] sw_en_in,
  input  wire logic [PORT_W-1:0] sw_val_in,
  output var  logic [PORT_W-1:0] pin_lvl_out
);
  // device driver wins, then switch, then pull-up; floating shows inverse
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (pin_oe_in[i])
        pin_lvl_out[i] = pin_out_in[i];
      else if (sw_en_in[i])
        pin_lvl_out[i] = sw_val_in[i];
      else if (pullup_en_in[i])
        pin_lvl_out[i] = 1'b1;
      else
        pin_lvl_out[i] = ~sw_val_in[i];
    end
  end
endmodule : gpb_keypad
`default_nettype wire

/* testbench/gpb_port_b_change_interrupt_test.sv */
// self-checking bench of gpb_port with a keypad model on the pins
// assumes waitrequest ends every access; clear holdoff of one instruction cycle
`timescale 1ns/10ps
`default_nettype none
module gpb_port_b_change_interrupt_test
  import gpb_pkg::*;
();
  logic        clk;
  logic        rst;
  gpb_av_req_t req;
  logic [31:0] rdata;
  logic        wreq;
  logic [7:0]  p_out;
  logic [7:0]  p_oe;
  logic [7:0]  p_pu;
  logic [7:0]  sw_val;
  logic [7:0]  sw_en;
  logic [7:0]  lvl;
  logic        cmp;
  logic        tclk;
  logic        wake;
  logic [31:0] r;
  int          miscompares;
  int          cmp_count;
  int          cyc;

  gpb_port i_dut (.core_clk_in(clk), .rst_in(rst), .av_req_in(req),
    .av_readdata_out(rdata), .av_waitrequest_out(wreq), .pin_in(lvl),
    .pin_out(p_out), .pin_oe_out(p_oe), .pullup_en_out(p_pu),
    .cmp_result_in(cmp), .timer_clk_out(tclk), .wake_out(wake));
  gpb_keypad i_pad (.pin_out_in(p_out), .pin_oe_in(p_oe), .pullup_en_in(p_pu),
    .sw_en_in(sw_en), .sw_val_in(sw_val), .pin_lvl_out(lvl));

  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic err(input string m);
    miscompares++;
    $display("[ERR] %0t %s", $time, m);
  endtask : err

  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) err("read data");
  endtask : chk_rd

  task automatic chk_pad(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) err("pad value");
  endtask : chk_pad

  task automatic chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) err("single bit");
  endtask : chk_bit

  // hold request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int   n;
    logic ok;
    n = 0;
    ok = 1'b0;
    @(posedge clk);
    req.read <= ~w;
    req.write <= w;
    req.address <= a;
    req.byteenable <= 4'hF;
    req.writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    ok = (wreq === 1'b0);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (!ok) err("bus hang");
    @(negedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0, r);
    chk_rd(r, {24'h0, e});
  endtask : rd

  task automatic settle(input logic [7:0] v);
    @(posedge clk);
    sw_val <= v;
    repeat (10) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic t_reset();
    chk_pad(p_oe, 8'h00);
    chk_pad(p_pu, 8'h00);
    rd(OFS_DIR, 8'hFF);
    rd(OFS_LATCH, 8'h00);
    rd(OFS_CTL2, 8'h80);
    rd(OFS_ANA, 8'h0F);
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00);
    rd(OFS_PORT, 8'hF0);
  endtask : t_reset

  task automatic t_dir_latch();
    wr(OFS_ANA, 8'h00);
    wr(OFS_PORT, 8'h3C);
    rd(OFS_LATCH, 8'h3C);
    wr(OFS_LATCH, 8'hA5);
    wr(OFS_DIR, 8'h0F);
    chk_pad(p_oe, 8'hF0);
    chk_pad(p_out, 8'hA5);
    settle(8'h5A);
    rd(OFS_PORT, 8'hAA);
    rd(OFS_LATCH, 8'hA5);
    wr(OFS_CTL2, 8'h00);
    chk_pad(p_pu, 8'h0F);
    @(posedge clk);
    sw_en <= 8'hF0;
    settle(8'h5F);
    rd(OFS_PORT, 8'hAF);
    wr(OFS_CTL2, 8'h80);
    chk_pad(p_pu, 8'h00);
    settle(8'h5F);
    rd(OFS_PORT, 8'hA0);
    @(posedge clk);
    sw_en <= 8'hFF;
  endtask : t_dir_latch

  task automatic t_change();
    wr(OFS_DIR, 8'hFF);
    settle(8'hFF);
    rd(OFS_PORT, 8'hFF);
    repeat (6) @(posedge clk);
    wr(OFS_CTL1, 8'h00);
    chk_bit(wake, 1'b0);
    settle(8'hF0);
    chk_bit(wake, 1'b0);
    rd(OFS_PORT, 8'hF0);
    settle(8'h70);
    chk_bit(wake, 1'b1);
    rd(OFS_CTL1, 8'h01);
    wr(OFS_CTL1, 8'h00);
    chk_bit(wake, 1'b1);
    rd(OFS_PORT, 8'h70);
    wr(OFS_CTL1, 8'h00);
    chk_bit(wake, 1'b1);
    repeat (INSTR_CYCLES) @(posedge clk);
    wr(OFS_CTL1, 8'h00);
    chk_bit(wake, 1'b0);
    wr(OFS_DIR, 8'h7F);
    settle(8'h70);
    chk_bit(wake, 1'b0);
  endtask : t_change

  task automatic t_pin5();
    wr(OFS_DIR, 8'hDF);
    wr(OFS_CTL2, 8'h81);
    @(posedge clk);
    cmp <= 1'b1;
    settle(8'h70);
    chk_bit(p_out[PIN5], 1'b1);
    chk_bit(tclk, 1'b1);
    @(posedge clk);
    cmp <= 1'b0;
    settle(8'h70);
    chk_bit(p_out[PIN5], 1'b0);
    chk_bit(tclk, 1'b0);
  endtask : t_pin5

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err("timeout");
      close_out();
    end
  end

  initial begin
    rst = 1'b1;
    req = '0;
    sw_val = 8'hFF;
    sw_en = 8'hFF;
    cmp = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_dir_latch();
    t_change();
    t_pin5();
    close_out();
  end
endmodule : gpb_port_b_change_interrupt_test
`default_nettype wire
